// ==== logic/vidbuf_defines.svh ====
// Purpose: Shared constants of the video buffer serial port.
// Assumes: 50 MHz system clock on the controller side.
// Notes:   Timing figures are in ns; cycle counts derive from them.
`ifndef VIDBUF_DEFINES_SVH
`define VIDBUF_DEFINES_SVH

// Fixed upper target address bits
`define TGT_FIXED      5'h0b
`define DIR_WRITE      1'b0
`define DIR_READ       1'b1

// Register select codes
`define SEL_CH1        3'h1
`define SEL_CH2        3'h2
`define SEL_CH3        3'h3
`define SEL_SYNC       3'h4
`define SUB_FILL       5'h00

// Reset and unmapped values
`define CFG_RESET      8'h00
`define UNMAPPED_READ  8'h00

// Bit slot of the acknowledge
`define ACK_SLOT       4'h8

// Serial clock quarter period
`define SYS_PERIOD_NS  20
`define SCL_QUARTER_NS 2500
`define SCL_QUARTER_CYC ((`SCL_QUARTER_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)

`endif

// ==== logic/vidbuf_pkg.sv ====
// Purpose: Types of the video buffer serial port.
// Assumes: Nothing beyond the defines header.
// Notes:   State of each end is one packed struct.
package vidbuf_pkg;

   typedef logic [7:0] cfg_byte_type;

   typedef enum logic [3:0] {
      TGT_IDLE      = 4'h0,
      TGT_ADDR      = 4'h1,
      TGT_ADDR_ACK  = 4'h2,
      TGT_SUB       = 4'h3,
      TGT_SUB_ACK   = 4'h4,
      TGT_WDATA     = 4'h5,
      TGT_WDATA_ACK = 4'h6,
      TGT_RDATA     = 4'h7,
      TGT_RDATA_ACK = 4'h8,
      TGT_IGNORE    = 4'h9
   } tgt_state_type;

   typedef enum logic [2:0] {
      OP_START = 3'h0,
      OP_TX    = 3'h1,
      OP_RX    = 3'h2,
      OP_STOP  = 3'h3,
      OP_END   = 3'h4
   } ctl_op_type;

   typedef enum logic {
      CTL_IDLE = 1'b0,
      CTL_RUN  = 1'b1
   } ctl_state_type;

   typedef struct packed {
      logic [1:0]         scl_sync;
      logic [1:0]         sda_sync;
      logic [1:0]         strap_s1;
      logic [1:0]         strap_s2;
      logic               scl_p;
      logic               sda_p;
      tgt_state_type      st;
      logic [3:0]         cnt;
      logic [7:0]         sh;
      logic               rd;
      logic [2:0]         ptr;
      logic               sda_oe;
      logic [3:0][7:0]    cfg;
   } tgt_regs_type;

   typedef struct packed {
      ctl_state_type      st;
      logic [3:0]         step;
      logic [1:0]         quarter;
      logic [7:0]         qcnt;
      logic [3:0]         bitn;
      logic               abort;
      logic               rd;
      logic [2:0]         sel;
      logic [7:0]         wdata;
      logic [1:0]         tsel;
      logic [1:0]         sda_sync;
      logic               scl_oe;
      logic               sda_oe;
      logic               busy;
      logic               done;
      logic               fail;
      logic [7:0]         rdata;
   } ctl_regs_type;

endpackage : vidbuf_pkg

// ==== logic/vidbuf_link_if.sv ====
// Purpose: Two-wire link between controller and target.
// Assumes: Pull-ups on both wires.
// Notes:   Wire levels are resolved here from the enables.
`timescale 1ns/10ps
interface vidbuf_link_if;
   logic scl;
   logic sda;
   logic host_scl_out;
   logic host_scl_oe;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;

   // Wired-and with pull-up
   assign scl = !(host_scl_oe && !host_scl_out);
   assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

   modport host (input scl, input sda, output host_scl_out, output host_scl_oe,
                 output host_sda_out, output host_sda_oe);
   modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe);
endinterface : vidbuf_link_if

// ==== logic/vidbuf_target.sv ====
// Purpose: Target end of the video buffer serial port.
// Assumes: LINK_CLK runs free and much faster than the serial clock.
// Notes:   Wires and straps are sampled through two flops.
//
// What this block does
// - Controller starts writes with start, address, 0.
// - Answer address 01011 plus two strap bits.
// - One subaddress byte follows address acknowledge.
// - Subaddress upper five bits are zero; the target does not check them.
// - Acknowledge subaddress in the ninth slot.
// - One data byte written, acknowledged, then stop.
// - No multi-byte transfers; one register each.
// - Read pointer set by write then stop.
// - Read address with direction 1 is acknowledged.
// - Drive one byte of the selected register.
// - Controller not-acknowledges read byte, then stops.
// - Each register read needs both phases.
// - Codes 1-3 channel, 4 sync register.
`timescale 1ns/10ps
`include "vidbuf_defines.svh"
module vidbuf_target (
   input  wire logic             LINK_CLK,
   input  wire logic             RESET,
   input  wire logic             CE,
   input  wire logic             ADDR_STRAP_HI_PIN,
   input  wire logic             ADDR_STRAP_LO_PIN,
   output vidbuf_pkg::cfg_byte_type CH1_CFG,
   output vidbuf_pkg::cfg_byte_type CH2_CFG,
   output vidbuf_pkg::cfg_byte_type CH3_CFG,
   output vidbuf_pkg::cfg_byte_type SYNC_CFG,
   vidbuf_link_if.dev            LINK
);
   import vidbuf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Register select decode

   function automatic logic sel_ok(input logic [2:0] sel);
      sel_ok = (sel >= `SEL_CH1) && (sel <= `SEL_SYNC);
   endfunction : sel_ok

   function automatic logic [1:0] sel_idx(input logic [2:0] sel);
      logic [2:0] diff;
      diff    = sel - `SEL_CH1;
      sel_idx = diff[1:0];
   endfunction : sel_idx

   ////////////////////////////////////////////////////////////////////////////////
   // State

   tgt_regs_type q;
   tgt_regs_type d;
   logic         scl_now;
   logic         sda_now;
   logic         start_ev;
   logic         stop_ev;
   logic         rise_ev;
   logic         fall_ev;
   logic [7:0]   rd_byte;
   logic [7:0]   sh_in;
   logic [7:0]   my_addr;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      d          = q;
      d.scl_sync = {q.scl_sync[0], LINK.scl};
      d.sda_sync = {q.sda_sync[0], LINK.sda};
      d.strap_s1 = {ADDR_STRAP_HI_PIN, ADDR_STRAP_LO_PIN};
      d.strap_s2 = q.strap_s1;
      scl_now    = q.scl_sync[1];
      sda_now    = q.sda_sync[1];
      d.scl_p    = scl_now;
      d.sda_p    = sda_now;
      // Start and stop are the only SDA moves while SCL is high
      start_ev   = scl_now && q.scl_p && q.sda_p && !sda_now;
      stop_ev    = scl_now && q.scl_p && !q.sda_p && sda_now;
      rise_ev    = scl_now && !q.scl_p;
      fall_ev    = !scl_now && q.scl_p;
      sh_in      = {q.sh[6:0], sda_now};
      my_addr    = {`TGT_FIXED, q.strap_s2, 1'b0};
      // Unmapped codes read back as a fixed value
      rd_byte    = sel_ok(q.ptr) ? q.cfg[sel_idx(q.ptr)] : `UNMAPPED_READ;

      case (q.st)
         TGT_IDLE:
         begin
         end
         TGT_ADDR:
         begin
            if (rise_ev)
            begin
               d.sh  = sh_in;
               d.cnt = q.cnt + 4'h1;
            end
            else if (fall_ev && (q.cnt == `ACK_SLOT))
            begin
               if (q.sh[7:1] == my_addr[7:1])
               begin
                  d.sda_oe = 1'b1;
                  d.rd     = q.sh[0];
                  d.st     = TGT_ADDR_ACK;
               end
               else
               begin
                  d.st = TGT_IGNORE;
               end
            end
         end
         TGT_ADDR_ACK:
         begin
            if (fall_ev)
            begin
               d.cnt = 4'h0;
               if (q.rd)
               begin
                  // First data bit goes out as the ack slot ends
                  d.sh     = rd_byte;
                  d.sda_oe = !rd_byte[7];
                  d.cnt    = 4'h1;
                  d.st     = TGT_RDATA;
               end
               else
               begin
                  d.sda_oe = 1'b0;
                  d.st     = TGT_SUB;
               end
            end
         end
         TGT_SUB:
         begin
            if (rise_ev)
            begin
               d.sh  = sh_in;
               d.cnt = q.cnt + 4'h1;
            end
            else if (fall_ev && (q.cnt == `ACK_SLOT))
            begin
               // Upper bits are not checked; only the low code counts
               d.ptr    = q.sh[2:0];
               d.sda_oe = 1'b1;
               d.st     = TGT_SUB_ACK;
            end
         end
         TGT_SUB_ACK:
         begin
            if (fall_ev)
            begin
               d.sda_oe = 1'b0;
               d.cnt    = 4'h0;
               d.st     = TGT_WDATA;
            end
         end
         TGT_WDATA:
         begin
            if (rise_ev)
            begin
               d.sh  = sh_in;
               d.cnt = q.cnt + 4'h1;
            end
            else if (fall_ev && (q.cnt == `ACK_SLOT))
            begin
               if (sel_ok(q.ptr))
               begin
                  d.cfg[sel_idx(q.ptr)] = q.sh;
               end
               d.sda_oe = 1'b1;
               d.st     = TGT_WDATA_ACK;
            end
         end
         TGT_WDATA_ACK:
         begin
            if (fall_ev)
            begin
               d.sda_oe = 1'b0;
               d.st     = TGT_IGNORE;
            end
         end
         TGT_RDATA:
         begin
            if (fall_ev)
            begin
               if (q.cnt == `ACK_SLOT)
               begin
                  d.sda_oe = 1'b0;
                  d.st     = TGT_RDATA_ACK;
               end
               else
               begin
                  d.sda_oe = !q.sh[6];
                  d.sh     = {q.sh[6:0], 1'b0};
                  d.cnt    = q.cnt + 4'h1;
               end
            end
         end
         TGT_RDATA_ACK:
         begin
            // Whatever the controller answers, only one byte is sent
            if (fall_ev)
            begin
               d.st = TGT_IGNORE;
            end
         end
         TGT_IGNORE:
         begin
         end
         default:
         begin
            d.st     = TGT_IDLE;
            d.sda_oe = 1'b0;
         end
      endcase

      // A repeated start aborts whatever byte was in flight
      if (start_ev)
      begin
         d.st     = TGT_ADDR;
         d.cnt    = 4'h0;
         d.sda_oe = 1'b0;
      end
      else if (stop_ev)
      begin
         d.st     = TGT_IDLE;
         d.sda_oe = 1'b0;
      end

      if (!CE)
      begin
         d = q;
      end
      if (RESET)
      begin
         d          = '0;
         d.st       = TGT_IDLE;
         d.scl_sync = 2'h3;
         d.sda_sync = 2'h3;
         d.scl_p    = 1'b1;
         d.sda_p    = 1'b1;
         d.cfg      = {4{`CFG_RESET}};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and outputs

   always_ff @(posedge LINK_CLK)
   begin
      q <= d;
   end

   assign CH1_CFG          = q.cfg[0];
   assign CH2_CFG          = q.cfg[1];
   assign CH3_CFG          = q.cfg[2];
   assign SYNC_CFG         = q.cfg[3];
   assign LINK.dev_sda_oe  = q.sda_oe;
   // Open drain: only ever pulls low
   assign LINK.dev_sda_out = 1'b0;

endmodule : vidbuf_target

// ==== logic/vidbuf_controller.sv ====
// Purpose: Controller end; runs one register write or read per request.
// Assumes: Target samples the wires on a clock well above SCL.
// Notes:   SCL is made here by dividing CLK_SYS; no clock stretching.
`timescale 1ns/10ps
`include "vidbuf_defines.svh"
module vidbuf_controller #(
   parameter int QUARTER_CYC = `SCL_QUARTER_CYC
) (
   input  wire logic             CLK_SYS,
   input  wire logic             RESET,
   input  wire logic             CE,
   input  wire logic             REQ,
   input  wire logic             REQ_READ,
   input  wire logic [2:0]       REQ_SEL,
   input  vidbuf_pkg::cfg_byte_type REQ_WDATA,
   input  wire logic [1:0]       TARGET_SEL,
   output logic                  BUSY,
   output logic                  DONE,
   output logic                  ACK_FAIL,
   output vidbuf_pkg::cfg_byte_type RDATA,
   vidbuf_link_if.host           LINK
);
   import vidbuf_pkg::*;

   // Target needs several of its own samples per quarter
   if (QUARTER_CYC < 20 || QUARTER_CYC > 255)
   begin : g_bad_quarter
      $error("QUARTER_CYC out of range 20..255");
   end

   localparam logic [7:0] QLAST = 8'(QUARTER_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Transaction scripts

   function automatic ctl_op_type op_of(input logic rd, input logic [3:0] step);
      case (step)
         4'h0:    op_of = OP_START;
         4'h1:    op_of = OP_TX;
         4'h2:    op_of = OP_TX;
         4'h3:    op_of = rd ? OP_STOP : OP_TX;
         4'h4:    op_of = rd ? OP_START : OP_STOP;
         4'h5:    op_of = rd ? OP_TX : OP_END;
         4'h6:    op_of = rd ? OP_RX : OP_END;
         4'h7:    op_of = rd ? OP_STOP : OP_END;
         default: op_of = OP_END;
      endcase
   endfunction : op_of

   function automatic logic [7:0] tx_byte(input ctl_regs_type r);
      case (r.step)
         4'h1:    tx_byte = {`TGT_FIXED, r.tsel, `DIR_WRITE};
         4'h2:    tx_byte = {`SUB_FILL, r.sel};
         4'h5:    tx_byte = {`TGT_FIXED, r.tsel, `DIR_READ};
         default: tx_byte = r.wdata;
      endcase
   endfunction : tx_byte

   // Except at start and stop, SDA moves only a quarter after SCL falls, never with it
   function automatic logic sda_low(input ctl_op_type op, input logic [1:0] qt,
                                    input logic [3:0] bitn, input logic [7:0] tb,
                                    input logic prev);
      logic [3:0] pos;
      pos = 4'h7 - bitn;
      case (op)
         OP_START: sda_low = qt[1];
         OP_STOP:  sda_low = (qt == 2'h0) ? prev : (qt != 2'h3);
         OP_TX:    sda_low = (qt == 2'h0) ? prev : (bitn != `ACK_SLOT) && !tb[pos[2:0]];
         default:  sda_low = (qt == 2'h0) ? prev : 1'b0;
      endcase
   endfunction : sda_low

   ////////////////////////////////////////////////////////////////////////////////
   // State

   ctl_regs_type q;
   ctl_regs_type d;
   ctl_op_type   op;
   logic         sda_in;

   always_comb
   begin
      d          = q;
      d.done     = 1'b0;
      d.sda_sync = {q.sda_sync[0], LINK.sda};
      sda_in     = q.sda_sync[1];
      op         = q.abort ? OP_STOP : op_of(q.rd, q.step);
      case (q.st)
         CTL_IDLE:
         begin
            if (REQ)
            begin
               d.st      = CTL_RUN;
               d.busy    = 1'b1;
               d.rd      = REQ_READ;
               d.sel     = REQ_SEL;
               d.wdata   = REQ_WDATA;
               d.tsel    = TARGET_SEL;
               d.step    = 4'h0;
               d.quarter = 2'h0;
               d.qcnt    = 8'h00;
               d.bitn    = 4'h0;
               d.abort   = 1'b0;
               d.fail    = 1'b0;
            end
         end
         CTL_RUN:
         begin
            d.scl_oe = ((op == OP_TX) || (op == OP_RX) || (op == OP_STOP)) && !q.quarter[1];
            d.sda_oe = sda_low(op, q.quarter, q.bitn, tx_byte(q), q.sda_oe);
            if (op == OP_END)
            begin
               d.st     = CTL_IDLE;
               d.busy   = 1'b0;
               d.done   = 1'b1;
               d.scl_oe = 1'b0;
               d.sda_oe = 1'b0;
            end
            else if (q.qcnt != QLAST)
            begin
               d.qcnt = q.qcnt + 8'h01;
            end
            else
            begin
               d.qcnt    = 8'h00;
               d.quarter = q.quarter + 2'h1;
               if (q.quarter == 2'h3)
               begin
                  if ((op == OP_TX) || (op == OP_RX))
                  begin
                     if (q.bitn == `ACK_SLOT)
                     begin
                        d.bitn = 4'h0;
                        if ((op == OP_TX) && sda_in)
                        begin
                           d.fail  = 1'b1;
                           d.abort = 1'b1;
                        end
                        else
                        begin
                           d.step = q.step + 4'h1;
                        end
                     end
                     else
                     begin
                        d.bitn = q.bitn + 4'h1;
                        if (op == OP_RX)
                        begin
                           d.rdata = {q.rdata[6:0], sda_in};
                        end
                     end
                  end
                  else if (q.abort)
                  begin
                     // Stop after a refused byte ends the request early
                     d.st    = CTL_IDLE;
                     d.busy  = 1'b0;
                     d.done  = 1'b1;
                     d.abort = 1'b0;
                  end
                  else
                  begin
                     d.step = q.step + 4'h1;
                  end
               end
            end
         end
         default:
         begin
            d.st = CTL_IDLE;
         end
      endcase
      if (!CE)
      begin
         d = q;
      end
      if (RESET)
      begin
         d          = '0;
         d.st       = CTL_IDLE;
         d.sda_sync = 2'h3;
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      q <= d;
   end

   assign BUSY              = q.busy;
   assign DONE              = q.done;
   assign ACK_FAIL          = q.fail;
   assign RDATA             = q.rdata;
   assign LINK.host_scl_oe  = q.scl_oe;
   assign LINK.host_sda_oe  = q.sda_oe;
   assign LINK.host_scl_out = 1'b0;
   assign LINK.host_sda_out = 1'b0;

endmodule : vidbuf_controller

// ==== tb/vidbuf_link_sva.sv ====
// Purpose: Wire-level checks on the two-wire link between both ends.
// Assumes: Signals taken straight from the link interface instance.
// Notes:   Two domains; each property names its own clock and reset.
`timescale 1ns/10ps
module vidbuf_link_sva (
   input wire logic clk_sys,
   input wire logic link_clk,
   input wire logic reset_sys,
   input wire logic reset_link,
   input wire logic scl,
   input wire logic sda,
   input wire logic host_scl_oe,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe
);
   ////////////////////////////////////////////////////////////////////////////
   property p_dev_stable_high;
      @(posedge link_clk) disable iff (reset_link) scl && $past(scl) |-> $stable(dev_sda_oe);
   endproperty
   a_dev_stable_high: assert property (p_dev_stable_high) else $error("target sda moved in scl high");
   property p_dev_pull_low;
      @(posedge link_clk) disable iff (reset_link) $rose(dev_sda_oe) |-> !scl;
   endproperty
   a_dev_pull_low: assert property (p_dev_pull_low) else $error("target pulled sda in scl high");
   property p_dev_release_low;
      @(posedge link_clk) disable iff (reset_link) $fell(dev_sda_oe) |-> !scl;
   endproperty
   a_dev_release_low: assert property (p_dev_release_low) else $error("target released sda in scl high");
   ////////////////////////////////////////////////////////////////////////////
   // Both pulling while scl high means a bit of the other end was lost
   property p_no_fight;
      @(posedge clk_sys) disable iff (reset_sys) scl |-> !(dev_sda_oe && host_sda_oe);
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("both ends drive sda in scl high");
   property p_start_low;
      @(posedge clk_sys) disable iff (reset_sys) $fell(sda) && scl |-> ##[1:60] !scl;
   endproperty
   a_start_low: assert property (p_start_low) else $error("no clock after start");
   property p_stop_idle;
      @(posedge clk_sys) disable iff (reset_sys)
         $rose(sda) && scl |=> (!host_scl_oe && !host_sda_oe && !dev_sda_oe) [*8];
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
   property p_scl_high_min;
      @(posedge clk_sys) disable iff (reset_sys) $fell(host_scl_oe) |=> !host_scl_oe [*8];
   endproperty
   a_scl_high_min: assert property (p_scl_high_min) else $error("scl high phase too short");
   property p_scl_low_min;
      @(posedge clk_sys) disable iff (reset_sys) $rose(host_scl_oe) |=> host_scl_oe [*8];
   endproperty
   a_scl_low_min: assert property (p_scl_low_min) else $error("scl low phase too short");
endmodule : vidbuf_link_sva

// ==== tb/tb.sv ====
// Purpose: Bench joining controller and target across one link.
// Assumes: Short quarter period of 20 cycles; link clock 80 ns.
// Notes:   A wire monitor captures the first 18 bits after each start.
`timescale 1ns/10ps
module tb;
   import vidbuf_pkg::*;
   localparam logic [3:0][7:0] WDAT = 32'h18244281;
   logic             clk_sys;
   logic             link_clk;
   logic             reset_sys;
   logic             reset_link;
   logic             ce;
   logic             req;
   logic             req_read;
   logic [2:0]       req_sel;
   cfg_byte_type     req_wdata;
   logic [1:0]       target_sel;
   logic [1:0]       strap;
   logic             busy;
   logic             done;
   logic             ack_fail;
   cfg_byte_type     rdata;
   cfg_byte_type     ch1;
   cfg_byte_type     ch2;
   cfg_byte_type     ch3;
   cfg_byte_type     sync_cfg;
   logic [17:0]      wire_bits;
   int               nbits;
   int               cycles;
   int               n_errors;
   int               n_compared;
   ////////////////////////////////////////////////////////////////////////////
   vidbuf_link_if link ();
   vidbuf_controller #(.QUARTER_CYC(20)) vidbuf_controller_inst (.CLK_SYS(clk_sys), .RESET(reset_sys),
      .CE(ce), .REQ(req), .REQ_READ(req_read), .REQ_SEL(req_sel), .REQ_WDATA(req_wdata),
      .TARGET_SEL(target_sel), .BUSY(busy), .DONE(done), .ACK_FAIL(ack_fail), .RDATA(rdata), .LINK(link));
   vidbuf_target vidbuf_target_inst (.LINK_CLK(link_clk), .RESET(reset_link), .CE(ce),
      .ADDR_STRAP_HI_PIN(strap[1]), .ADDR_STRAP_LO_PIN(strap[0]), .CH1_CFG(ch1), .CH2_CFG(ch2),
      .CH3_CFG(ch3), .SYNC_CFG(sync_cfg), .LINK(link));
   vidbuf_link_sva vidbuf_link_sva_inst (.clk_sys(clk_sys), .link_clk(link_clk), .reset_sys(reset_sys),
      .reset_link(reset_link), .scl(link.scl), .sda(link.sda), .host_scl_oe(link.host_scl_oe),
      .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe));
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Odd offset keeps the two clocks out of phase
   initial
   begin
      link_clk = 1'b0;
      #7;
      forever #40 link_clk = ~link_clk;
   end
   // Start restarts the capture of address byte and the byte after it
   always @(negedge link.sda)
      if (link.scl === 1'b1)
         nbits = 0;
   always @(posedge link.scl)
      if (nbits < 18)
      begin
         wire_bits = {wire_bits[16:0], link.sda};
         nbits = nbits + 1;
      end
   always @(posedge clk_sys)
   begin
      cycles = cycles + 1;
      if (cycles == 60000)
      begin
         n_errors = n_errors + 1;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
         n_errors = n_errors + 1;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Entered at a falling edge; returns at the falling edge inside the done pulse
   task automatic do_req(input logic rd, input logic [2:0] sel, input cfg_byte_type wd, input logic [1:0] ts);
      int k;
      k = 0;
      req = 1'b1;
      req_read = rd;
      req_sel = sel;
      req_wdata = wd;
      target_sel = ts;
      @(negedge clk_sys);
      req = 1'b0;
      while (done !== 1'b1 && k < 5000)
      begin
         @(negedge clk_sys);
         k = k + 1;
      end
      check(32'(done), 32'h1);
   endtask : do_req
   ////////////////////////////////////////////////////////////////////////////
   // Back to back: each write starts in the done cycle of the last
   task automatic t_write_all();
      for (int i = 0; i < 4; i++)
      begin
         do_req(1'b0, 3'(i + 1), WDAT[i], 2'b10);
         check(32'(ack_fail), 32'h0);
         check(32'(wire_bits), 32'({5'h0b, 2'b10, 1'b0, 1'b0, 5'h00, 3'(i + 1), 1'b0}));
      end
      check({ch1, ch2, ch3, sync_cfg}, {WDAT[0], WDAT[1], WDAT[2], WDAT[3]});
   endtask : t_write_all
   task automatic t_write_unmapped();
      logic [3:0][2:0] codes;
      codes = {3'h7, 3'h6, 3'h5, 3'h0};
      for (int i = 0; i < 4; i++)
      begin
         do_req(1'b0, codes[i], 8'hff, 2'b10);
         check(32'(ack_fail), 32'h0);
      end
      check({ch1, ch2, ch3, sync_cfg}, {WDAT[0], WDAT[1], WDAT[2], WDAT[3]});
   endtask : t_write_unmapped
   task automatic t_read_all();
      cfg_byte_type exp;
      for (int i = 0; i < 5; i++)
      begin
         exp = (i < 4) ? WDAT[i] : 8'h00;
         do_req(1'b1, (i < 4) ? 3'(i + 1) : 3'h7, 8'h00, 2'b10);
         check(32'(rdata), 32'(exp));
         check(32'(wire_bits), 32'({5'h0b, 2'b10, 1'b1, 1'b0, exp, 1'b1}));
      end
   endtask : t_read_all
   task automatic t_foreign();
      do_req(1'b0, 3'h1, 8'hee, 2'b01);
      check(32'(ack_fail), 32'h1);
      // The stop's clock pulse after the refused ack is captured as a tenth bit
      check(32'(wire_bits[9:0]), 32'({5'h0b, 2'b01, 1'b0, 1'b1, 1'b0}));
      check(32'(ch1), 32'(WDAT[0]));
   endtask : t_foreign
   task automatic t_strap();
      logic [1:0] w;
      strap = 2'b01;
      repeat (40) @(negedge clk_sys);
      do_req(1'b0, 3'h2, 8'h99, 2'b01);
      check(32'(ack_fail), 32'h0);
      check(32'(ch2), 32'h99);
      // Freeze both ends mid-address; the wires must not move meanwhile
      fork
         do_req(1'b0, 3'h1, 8'h5a, 2'b01);
         begin
            repeat (300) @(negedge clk_sys);
            ce = 1'b0;
            repeat (2) @(negedge clk_sys);
            w = {link.scl, link.sda};
            repeat (100) @(negedge clk_sys);
            check(32'({link.scl, link.sda}), 32'(w));
            check(32'(busy), 32'h1);
            ce = 1'b1;
         end
      join
      check(32'(ack_fail), 32'h0);
      check(32'(ch1), 32'h5a);
      do_req(1'b0, 3'h3, 8'h77, 2'b10);
      check(32'(ack_fail), 32'h1);
      check(32'(ch3), 32'(WDAT[2]));
   endtask : t_strap
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      req = 1'b0;
      req_read = 1'b0;
      ce = 1'b1;
      req_sel = 3'h0;
      req_wdata = 8'h00;
      target_sel = 2'b10;
      strap = 2'b10;
      reset_sys = 1'b1;
      reset_link = 1'b1;
      wire_bits = 18'h0;
      nbits = 0;
      cycles = 0;
      n_errors = 0;
      n_compared = 0;
      repeat (3) @(posedge link_clk);
      @(negedge link_clk);
      reset_link = 1'b0;
      repeat (3) @(negedge clk_sys);
      reset_sys = 1'b0;
      // Target sync chain needs a few link edges before the first start
      repeat (16) @(negedge clk_sys);
      check({ch1, ch2, ch3, sync_cfg}, 32'h0);
      t_write_all();
      t_write_unmapped();
      t_read_all();
      t_foreign();
      t_strap();
      test_done();
   end
endmodule : tb
